// file: inc/asc_pkg.sv
package asc_pkg;
    // Geometry of the attached memory
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    // Clock period of the controller
    localparam int CLK_PERIOD_NS = 100;
    // Device timing for the slowest grade (ns)
    localparam int ADDRESS_ACCESS_DELAY_NS     = 120;
    localparam int OE_ACCESS_NS                = 60;
    localparam int READ_CYCLE_PERIOD_NS        = 120;
    localparam int WRITE_PULSE_NS              = 70;
    localparam int WRITE_DATA_LEAD_NS          = 50;
    localparam int RETENTION_RECOVERY_DELAY_NS = READ_CYCLE_PERIOD_NS;
    // Least times round up, never below one cycle
    localparam int READ_WAIT_CYC = (ADDRESS_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC     = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC   = (RETENTION_RECOVERY_DELAY_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [7:0] RD_DATA_RST = 8'h00;
    typedef enum logic [2:0] {
        ASC_IDLE,
        ASC_RD_SETUP,
        ASC_RD_WAIT,
        ASC_WR_SETUP,
        ASC_WR_PULSE,
        ASC_WR_END,
        ASC_RETAIN,
        ASC_RECOVER
    } asc_state_t;
endpackage

// file: src/asc_sram_host.sv
`timescale 1ns/10ps
`default_nettype none
module asc_sram_host
    import asc_pkg::*;
(
    input  wire logic                        clk_i,
    input  wire logic                        resetn_i,
    input  wire logic                        ce_i,
    input  wire logic                        req_valid_i,
    input  wire logic                        req_write_i,
    input  wire logic [asc_pkg::ADDR_W-1:0]  req_addr_i,
    input  wire logic [asc_pkg::DATA_W-1:0]  req_wdata_i,
    input  wire logic                        retain_i,
    output logic                             req_ready_o,
    output logic                             rsp_valid_o,
    output logic [asc_pkg::DATA_W-1:0]       rsp_rdata_o,
    output logic                             retained_o,
    output logic [asc_pkg::ADDR_W-1:0]       word_address_lines_o,
    output logic                             cs_n_o,
    output logic                             oe_n_o,
    output logic                             we_n_o,
    input  wire logic [asc_pkg::DATA_W-1:0]  shared_byte_lines_i,
    output logic [asc_pkg::DATA_W-1:0]       shared_byte_lines_o,
    output logic                             shared_byte_lines_oe_n_o
);
    import asc_pkg::*;

    asc_state_t        state_reg, state_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic              rsp_reg, rsp_next;
    logic [DATA_W-1:0] din_meta_reg, din_sync_reg;

    // Read data comes from another timing world, two flops first
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            din_meta_reg <= RD_DATA_RST;
            din_sync_reg <= RD_DATA_RST;
        end else if (ce_i) begin
            din_meta_reg <= shared_byte_lines_i;
            din_sync_reg <= din_meta_reg;
        end
    end

    // Sequencer next state; one request at a time, no refresh needed
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        rsp_next   = 1'b0;
        unique case (state_reg)
            ASC_IDLE: begin
                if (retain_i) begin
                    state_next = ASC_RETAIN;
                end else if (req_valid_i) begin
                    // Address latched while strobes idle
                    addr_next  = req_addr_i;
                    wdata_next = req_wdata_i;
                    state_next = req_write_i ? ASC_WR_SETUP : ASC_RD_SETUP;
                end
            end
            ASC_RD_SETUP: begin
                cnt_next   = CNT_W'(READ_WAIT_CYC);
                state_next = ASC_RD_WAIT;
            end
            ASC_RD_WAIT: begin
                if (cnt_reg == CNT_ZERO) begin
                    // Sampled data is the synced copy, two cycles old
                    rdata_next = din_sync_reg;
                    rsp_next   = 1'b1;
                    state_next = ASC_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ASC_WR_SETUP: begin
                cnt_next   = CNT_W'(WRITE_CYC - 1);
                state_next = ASC_WR_PULSE;
            end
            ASC_WR_PULSE: begin
                if (cnt_reg == CNT_ZERO) begin
                    state_next = ASC_WR_END;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ASC_WR_END: begin
                rsp_next   = 1'b1;
                state_next = ASC_IDLE;
            end
            ASC_RETAIN: begin
                if (!retain_i) begin
                    cnt_next   = CNT_W'(RECOVER_CYC - 1);
                    state_next = ASC_RECOVER;
                end
            end
            ASC_RECOVER: begin
                if (cnt_reg == CNT_ZERO) begin
                    state_next = ASC_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_reg <= ASC_IDLE;
            cnt_reg   <= CNT_ZERO;
            addr_reg  <= '0;
            wdata_reg <= '0;
            rdata_reg <= RD_DATA_RST;
            rsp_reg   <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            rsp_reg   <= rsp_next;
        end
    end

    // Pin strobes decoded combinationally from the 3-bit binary state, not registered
    always_comb begin
        cs_n_o = !(state_reg inside {ASC_RD_SETUP, ASC_RD_WAIT, ASC_WR_SETUP,
                                     ASC_WR_PULSE, ASC_WR_END});
        we_n_o = (state_reg != ASC_WR_PULSE);
        oe_n_o = !(state_reg == ASC_RD_WAIT);
        // Drive data across the whole write, released at once otherwise
        shared_byte_lines_oe_n_o = !(state_reg inside {ASC_WR_SETUP, ASC_WR_PULSE,
                                                       ASC_WR_END});
    end

    assign word_address_lines_o = addr_reg;
    assign shared_byte_lines_o  = wdata_reg;
    assign rsp_rdata_o          = rdata_reg;
    assign rsp_valid_o          = rsp_reg;
    assign req_ready_o          = (state_reg == ASC_IDLE) && !retain_i;
    assign retained_o           = (state_reg == ASC_RETAIN);

    // Helper count of strobe-low cycles; feeds only the width check below
    logic [CNT_W-1:0] we_low_reg, we_low_next;

    // Saturates so a long or frozen strobe cannot wrap back to short
    always_comb begin
        we_low_next = we_low_reg;
        if (we_n_o) begin
            we_low_next = CNT_ZERO;
        end else if (we_low_reg != '1) begin
            we_low_next = we_low_reg + 1'b1;
        end
    end

    // Helper count register, frozen with the rest of the state
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            we_low_reg <= CNT_ZERO;
        end else if (ce_i) begin
            we_low_reg <= we_low_next;
        end
    end

    // Checks on the pin sequence
    AST_WE_ONLY_SELECTED: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !we_n_o |-> !cs_n_o && oe_n_o && !shared_byte_lines_oe_n_o)
        else $error("write strobe low without select or data");
    AST_NO_CONTENTION: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !oe_n_o |-> shared_byte_lines_oe_n_o && we_n_o)
        else $error("host drives data while gate is low");
    AST_ADDR_STABLE: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i && !we_n_o |=> $stable(word_address_lines_o))
        else $error("address moved during write strobe");
    AST_WRITE_WIDTH: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(we_n_o) |-> we_low_reg >= CNT_W'(WRITE_CYC))
        else $error("write pulse too short");
    AST_DATA_LEAD: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(we_n_o) |-> !shared_byte_lines_oe_n_o && !$past(shared_byte_lines_oe_n_o))
        else $error("write data not held across strobe end");
    AST_READ_WAIT: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i && state_reg == ASC_RD_SETUP ##1 ce_i [*2] |-> !oe_n_o)
        else $error("gate not low during read wait");
    AST_READ_SAMPLE: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state_reg == ASC_RD_WAIT && cnt_reg == CNT_ZERO
            |-> !$past(oe_n_o, 2) && $stable(word_address_lines_o))
        else $error("read sampled before gate and address settled");
    AST_ADDR_HELD: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !cs_n_o && !$past(cs_n_o) |-> $stable(word_address_lines_o))
        else $error("address moved while selected");
    AST_DESELECT_IDLE: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        cs_n_o |-> oe_n_o && we_n_o && shared_byte_lines_oe_n_o)
        else $error("strobes or data active while deselected");
    AST_RETAIN_CS: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        retained_o |-> cs_n_o)
        else $error("select low during retention");
    AST_RECOVER: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i && $fell(retained_o) |-> cs_n_o && !req_ready_o)
        else $error("access too soon after retention");
    AST_RD_WE_HIGH: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !oe_n_o |-> we_n_o && !cs_n_o)
        else $error("write strobe low in read");
endmodule
`default_nettype wire

// file: bench/asc_sram_model.sv
`timescale 1ns/10ps
`default_nettype none
module asc_sram_model
    import asc_pkg::*;
#(
    parameter int ACC_NS = 120,
    parameter int OE_NS  = 60
)(
    input  wire logic              cs_n_i,
    input  wire logic              oe_n_i,
    input  wire logic              we_n_i,
    input  wire logic              host_oe_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0]      data_o,
    output int                     fault_o
);
    logic [DATA_W-1:0] mem [0:32767];
    logic [ADDR_W-1:0] addr_late;
    logic              oe_late;
    logic              drive;
    logic              wr_on;
    realtime           t_wr;
    realtime           t_dat;
    // Inertial delays stand in for the access times
    assign #(ACC_NS) addr_late = addr_i;
    assign #(OE_NS) oe_late = oe_n_i;
    assign drive = !cs_n_i && !oe_n_i && we_n_i;
    assign wr_on = !cs_n_i && !we_n_i;
    // No pull-up, so an unready or released byte shows inverted
    assign data_o = (drive && !oe_late && addr_late == addr_i) ? mem[addr_i] : ~mem[addr_i];
    // Store when the overlap closes; time the pulse and data lead
    initial fault_o = 0;
    initial t_wr = 0;
    always @(posedge wr_on) t_wr = $realtime;
    always @(data_i) t_dat = $realtime;
    always @(negedge wr_on) if (t_wr > 0) begin
        mem[addr_i] = data_i;
        if ($realtime - t_wr < WRITE_PULSE_NS || $realtime - t_dat < WRITE_DATA_LEAD_NS)
            fault_o++;
    end
    // Host slips on the pins are only counted
    always @(addr_i) if (wr_on) fault_o++;
    always @(drive, host_oe_n_i) if (drive && !host_oe_n_i) fault_o++;
endmodule
`default_nettype wire

// file: bench/asc_sram_host_bench.sv
`timescale 1ns/10ps
`default_nettype none
module asc_sram_host_bench;
    import asc_pkg::*;
    logic              clk_i, resetn_i, ce_i, req_valid_i, req_write_i, retain_i, hoe_n;
    logic              req_ready_o, rsp_valid_o, retained_o, cs_n_o, oe_n_o, we_n_o;
    logic [ADDR_W-1:0] req_addr_i, word_address_lines_o;
    logic [DATA_W-1:0] req_wdata_i, rsp_rdata_o, host_d, dev_d, pins;
    int                fail_count, checked, dev_fault;
    // Host wins the byte lines only while it enables them
    assign pins = hoe_n ? dev_d : host_d;
    asc_sram_host u_dut (.clk_i, .resetn_i, .ce_i, .req_valid_i, .req_write_i, .req_addr_i,
        .req_wdata_i, .retain_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .retained_o,
        .word_address_lines_o, .cs_n_o, .oe_n_o, .we_n_o, .shared_byte_lines_i(pins),
        .shared_byte_lines_o(host_d), .shared_byte_lines_oe_n_o(hoe_n));
    asc_sram_model u_mem (.cs_n_i(cs_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
        .host_oe_n_i(hoe_n), .addr_i(word_address_lines_o), .data_i(pins), .data_o(dev_d),
        .fault_o(dev_fault));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic wrap_up;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One request; stall freezes the clock enable in mid-access
    task automatic xfer(input logic wr, input logic [14:0] a, input logic [7:0] d, input int stall);
        int n;
        n = 0;
        chk(req_ready_o, 16'h0001, "not ready");
        {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, wr, a, d};
        @(negedge clk_i);
        req_valid_i = 1'b0;
        while (rsp_valid_o !== 1'b1 && n < 20) begin
            if (n == 2 && stall > 0) begin
                ce_i = 1'b0;
                repeat (stall) @(negedge clk_i);
                ce_i = 1'b1;
            end
            if (wr) chk(oe_n_o, 16'h0001, "gate low in write");
            else chk(we_n_o, 16'h0001, "strobe low in read");
            @(negedge clk_i);
            n++;
        end
        chk(16'(n), wr ? 16'(WRITE_CYC + 2) : 16'(READ_WAIT_CYC + 2), "latency");
        if (!wr) chk(rsp_rdata_o, d, "read data");
    endtask
    // Hold, release, then the recovery gap before any access
    task automatic retain;
        retain_i = 1'b1;
        @(negedge clk_i);
        chk({retained_o, cs_n_o, req_ready_o}, 16'h0006, "enter hold");
        repeat (3) @(negedge clk_i);
        retain_i = 1'b0;
        @(negedge clk_i);
        chk({cs_n_o, req_ready_o}, 16'h0002, "recovery");
        repeat (2) @(negedge clk_i);
        chk(req_ready_o, 16'h0001, "back");
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Run is about 44 cycles; far beyond that is a hang
    initial begin
        repeat (2000) @(posedge clk_i);
        fail_count++;
        wrap_up;
    end
    initial begin
        {resetn_i, req_valid_i, req_write_i, retain_i, req_addr_i, req_wdata_i} = 0;
        ce_i = 1'b1;
        repeat (12) @(negedge clk_i);
        chk({cs_n_o, oe_n_o, we_n_o, hoe_n, rsp_valid_o, req_ready_o}, 16'h003D, "reset");
        chk(word_address_lines_o, 16'h0000, "reset address");
        resetn_i = 1'b1;
        xfer(1'b1, 15'h0000, 8'hA5, 0);
        xfer(1'b1, 15'h7FFF, 8'h5A, 0);
        xfer(1'b0, 15'h0000, 8'hA5, 0);
        xfer(1'b0, 15'h7FFF, 8'h5A, 2);
        retain;
        xfer(1'b0, 15'h0000, 8'hA5, 0);
        chk(16'(dev_fault), 16'h0000, "pin faults");
        wrap_up;
    end
endmodule
`default_nettype wire
